// file: include/nvsram_slave_defines.vh
`ifndef NVSRAM_SLAVE_DEFINES_VH
`define NVSRAM_SLAVE_DEFINES_VH
// memory select code in bits 7:4 of the slave select byte
`define MEM_CODE             4'ha
// byte geometry
`define BYTE_BITS            4'h8
`define ACK_BIT              4'h8
`define LAST_BIT             4'h7
// address geometry
`define ADDR_W               17
`define ADDR_ZERO            17'h00000
`define ADDR_ONE             17'h00001
// reset levels of the synchronised pins: clock, data and store pin high, rest low
`define PIN_IDLE             6'h38
// store busy high drive time in ns and its cycle count at 10 MHz
`define STORE_HIGH_NS        100
`define CLK_PERIOD_NS        100
`define STORE_HIGH_CYC       ((`STORE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// store duration in cycles, default value of a parameter
`define STORE_CYC_DEFAULT    16'h0040
// fifo geometry
`define FIFO_WIDTH           25
`define FIFO_DEPTH           16
`endif

// file: src/i2c_nvsram_memory_slave.v
`include "nvsram_slave_defines.vh"
module i2c_nvsram_memory_slave #(
    parameter ADDR_W    = `ADDR_W,
    parameter STORE_CYC = `STORE_CYC_DEFAULT,
    parameter FIFO_W    = `FIFO_WIDTH,
    parameter FIFO_D    = `FIFO_DEPTH
) (
    input  wire              ref_clk_in,            // system clock, 10 MHz
    input  wire              sys_rst_in,            // async reset, active high
    input  wire              scl_in,                // serial clock pin
    input  wire              sda_in,                // serial data pin level
    output reg               sda_out,               // data pin drive value, always low
    output reg               sda_oe_n_out,          // low while pulling data low
    input  wire              write_protect_in,      // high blocks array writes
    input  wire [1:0]        address_select_pins_in,// device select straps
    input  wire              store_busy_pin_in,     // store busy pin level
    output reg               store_busy_pin_out,    // store busy drive value
    output reg               store_busy_pin_oe_n_out,// low while driving the pin
    output reg               mem_wr_out,            // array write strobe, one cycle
    output reg [ADDR_W-1:0]  mem_addr_out,          // array address
    output reg [7:0]         mem_wdata_out,         // array write data
    input  wire [7:0]        mem_rdata_in           // array read data, same clock
);
    // bus phases
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_RXBIT = 3'h1;
    localparam [2:0] ST_RXACK = 3'h2;
    localparam [2:0] ST_TXBIT = 3'h3;
    localparam [2:0] ST_TXACK = 3'h4;
    localparam [2:0] ST_IGN   = 3'h5;
    // byte roles within a transaction
    localparam [1:0] RB_SEL   = 2'h0;
    localparam [1:0] RB_AHI   = 2'h1;
    localparam [1:0] RB_ALO   = 2'h2;
    localparam [1:0] RB_DATA  = 2'h3;
    // store busy pin phases
    localparam [1:0] SB_IDLE  = 2'h0;
    localparam [1:0] SB_BUSY  = 2'h1;
    localparam [1:0] SB_HIGH  = 2'h2;
    localparam [15:0] HIGH_CYC = `STORE_HIGH_CYC;

    // address wrap and increment, used by reads and writes
    function [ADDR_W-1:0] next_addr;
        input [ADDR_W-1:0] a;
        begin
            next_addr = a + `ADDR_ONE;
        end
    endfunction

    // synchronised pins
    wire        scl;
    wire        sda;
    wire        wp;
    wire        store_busy_pin;
    wire [1:0]  straps;
    // idle levels at reset, so no false edge follows; link rate up to an eighth of ref clock
    pin_sync #(.WIDTH(6), .INIT(`PIN_IDLE)) u_sync (
        .clk_in (ref_clk_in),
        .rst_in (sys_rst_in),
        .d_in   ({scl_in, sda_in, store_busy_pin_in, write_protect_in,
                  address_select_pins_in}),
        .q_out  ({scl, sda, store_busy_pin, wp, straps})
    );

    reg         scl_d;
    reg         sda_d;
    reg [2:0]   state;
    reg [1:0]   role;
    reg [3:0]   bit_cnt;
    reg [7:0]   shreg;
    reg         is_read;
    reg         got_ack;
    reg [ADDR_W-1:0] cur_addr;
    reg [ADDR_W-1:0] load_addr;
    reg [1:0]   sb_state;
    reg [15:0]  sb_cnt;
    reg         hsb_d;

    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    // start and stop only while clock high and steady
    wire start_det = scl & scl_d & sda_d & ~sda;
    wire stop_det  = scl & scl_d & ~sda_d & sda;
    // data sampled at clock rise, when stable
    wire rx_bit    = sda;

    // select byte decode: code and straps; top bit and direction latched on a match
    wire sel_match = (shreg[7:4] == `MEM_CODE) &&
                     (shreg[3:2] == straps);

    // fifo carries array writes: address plus data
    wire              f_wready;
    wire              f_rvalid;
    wire [FIFO_W-1:0] f_rdata;
    reg               f_push;
    reg  [FIFO_W-1:0] f_wdata;
    sync_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D), .AW(4)) u_fifo (
        .clk_in       (ref_clk_in),
        .rst_in       (sys_rst_in),
        .wr_valid_in  (f_push),
        .wr_ready_out (f_wready),
        .wr_data_in   (f_wdata),
        .rd_valid_out (f_rvalid),
        .rd_ready_in  (~(state == ST_TXBIT) && (sb_state != SB_BUSY)),
        .rd_data_out  (f_rdata)
    );
    wire f_pop = f_rvalid && ~(state == ST_TXBIT) && (sb_state != SB_BUSY);

    // serial protocol engine
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_d        <= 1'b1;
            sda_d        <= 1'b1;
            state        <= ST_IDLE;
            role         <= RB_SEL;
            bit_cnt      <= 4'h0;
            shreg        <= 8'h00;
            is_read      <= 1'b0;
            got_ack      <= 1'b0;
            cur_addr     <= `ADDR_ZERO;
            load_addr    <= `ADDR_ZERO;
            sda_out      <= 1'b0;
            sda_oe_n_out <= 1'b1;
            f_push       <= 1'b0;
            f_wdata      <= {FIFO_W{1'b0}};
        end else begin
            scl_d  <= scl;
            sda_d  <= sda;
            f_push <= 1'b0;
            sda_out <= 1'b0;
            if (stop_det) begin
                state        <= ST_IDLE;
                sda_oe_n_out <= 1'b1;
            end else if (start_det) begin
                state        <= ST_RXBIT;
                role         <= RB_SEL;
                bit_cnt      <= 4'h0;
                sda_oe_n_out <= 1'b1;
            end else begin
                case (state)
                    ST_RXBIT: begin
                        if (scl_rise) begin
                            shreg   <= {shreg[6:0], rx_bit};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == `BYTE_BITS) begin
                            bit_cnt <= 4'h0;
                            state   <= ST_RXACK;
                            case (role)
                                RB_SEL: begin
                                    if (sel_match) begin
                                        sda_oe_n_out <= 1'b0;
                                        is_read      <= shreg[0];
                                        load_addr    <= {shreg[1], load_addr[15:0]};
                                    end else begin
                                        state <= ST_IGN;
                                    end
                                end
                                RB_AHI: begin
                                    sda_oe_n_out <= 1'b0;
                                    load_addr    <= {load_addr[16], shreg, load_addr[7:0]};
                                end
                                RB_ALO: begin
                                    sda_oe_n_out <= 1'b0;
                                    cur_addr     <= {load_addr[16:8], shreg};
                                end
                                default: begin
                                    if (wp || !f_wready) begin
                                        state <= ST_IGN;
                                    end else begin
                                        sda_oe_n_out <= 1'b0;
                                        f_push       <= 1'b1;
                                        f_wdata      <= {cur_addr, shreg};
                                        cur_addr     <= next_addr(cur_addr);
                                    end
                                end
                            endcase
                        end
                    end
                    ST_RXACK: begin
                        // release after the ninth clock falls
                        if (scl_fall) begin
                            sda_oe_n_out <= 1'b1;
                            if (role == RB_SEL && is_read) begin
                                state        <= ST_TXBIT;
                                shreg        <= mem_rdata_in;
                                sda_oe_n_out <= mem_rdata_in[7];
                                bit_cnt      <= 4'h0;
                            end else begin
                                state <= ST_RXBIT;
                                if (role != RB_DATA) begin
                                    role <= role + 2'h1;
                                end
                            end
                        end
                    end
                    ST_TXBIT: begin
                        if (scl_fall) begin
                            if (bit_cnt == `LAST_BIT) begin
                                sda_oe_n_out <= 1'b1;
                                state        <= ST_TXACK;
                                cur_addr     <= next_addr(cur_addr);
                            end else begin
                                shreg        <= {shreg[6:0], 1'b0};
                                sda_oe_n_out <= shreg[6];
                                bit_cnt      <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (scl_rise) begin
                            got_ack <= ~rx_bit;
                        end else if (scl_fall) begin
                            if (got_ack) begin
                                state        <= ST_TXBIT;
                                shreg        <= mem_rdata_in;
                                sda_oe_n_out <= mem_rdata_in[7];
                                bit_cnt      <= 4'h0;
                            end else begin
                                state <= ST_IGN;
                            end
                        end
                    end
                    ST_IGN: begin
                        sda_oe_n_out <= 1'b1;
                    end
                    default: begin
                        sda_oe_n_out <= 1'b1;
                    end
                endcase
            end
        end
    end

    // array port: drain writes, otherwise present current address
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mem_wr_out    <= 1'b0;
            mem_addr_out  <= `ADDR_ZERO;
            mem_wdata_out <= 8'h00;
        end else begin
            mem_wr_out <= f_pop;
            if (f_pop) begin
                mem_addr_out  <= f_rdata[FIFO_W-1:8];
                mem_wdata_out <= f_rdata[7:0];
            end else begin
                mem_addr_out  <= cur_addr;
            end
        end
    end

    // store busy pin: external low requests a store
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sb_state                <= SB_IDLE;
            sb_cnt                  <= 16'h0000;
            hsb_d                   <= 1'b1;
            store_busy_pin_out      <= 1'b1;
            store_busy_pin_oe_n_out <= 1'b1;
        end else begin
            hsb_d <= store_busy_pin;
            case (sb_state)
                SB_IDLE: begin
                    store_busy_pin_oe_n_out <= 1'b1;
                    if (hsb_d && !store_busy_pin) begin
                        sb_state                <= SB_BUSY;
                        sb_cnt                  <= STORE_CYC[15:0];
                        store_busy_pin_out      <= 1'b0;
                        store_busy_pin_oe_n_out <= 1'b0;
                    end
                end
                SB_BUSY: begin
                    if (sb_cnt == 16'h0001) begin
                        sb_state           <= SB_HIGH;
                        sb_cnt             <= HIGH_CYC;
                        store_busy_pin_out <= 1'b1;
                    end else begin
                        sb_cnt <= sb_cnt - 16'h0001;
                    end
                end
                SB_HIGH: begin
                    if (sb_cnt == 16'h0001) begin
                        sb_state                <= SB_IDLE;
                        store_busy_pin_oe_n_out <= 1'b1;
                    end else begin
                        sb_cnt <= sb_cnt - 16'h0001;
                    end
                end
                default: begin
                    sb_state <= SB_IDLE;
                end
            endcase
        end
    end
endmodule // i2c_nvsram_memory_slave

// file: src/pin_sync.v
// two flip-flop synchroniser for a group of pins
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clk_in,   // sampling clock
    input  wire             rst_in,   // async reset, active high
    input  wire [WIDTH-1:0] d_in,     // asynchronous pins
    output reg  [WIDTH-1:0] q_out     // synchronised pins
);
    reg [WIDTH-1:0] meta;

    // first stage read only by the second
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta  <= INIT;
            q_out <= INIT;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule // pin_sync

// file: src/sync_fifo.v
// flip-flop fifo with valid and ready on both sides
module sync_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_in,      // clock
    input  wire             rst_in,      // async reset, active high
    input  wire             wr_valid_in, // write word offered
    output wire             wr_ready_out,// room for a word
    input  wire [WIDTH-1:0] wr_data_in,  // write word
    output wire             rd_valid_out,// word available
    input  wire             rd_ready_in, // drain side takes word
    output wire [WIDTH-1:0] rd_data_out  // head word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign wr_ready_out = (count != DEPTH[AW:0]);
    assign rd_valid_out = (count != {(AW+1){1'b0}});
    assign rd_data_out  = mem[rd_ptr];
    assign push         = wr_valid_in & wr_ready_out;
    assign pop          = rd_valid_out & rd_ready_in;

    // storage, no reset needed
    always @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= wr_data_in;
        end
    end

    // pointers and fill count
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // sync_fifo

// file: test/i2c_master_model.sv
module i2c_master_model (
    input  wire logic clk_in,     // bench clock
    input  wire logic sda_in,     // resolved data wire
    output logic      scl_out,    // serial clock, high when idle
    output logic      sda_low_out // high while pulling data low
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus: clock stands high, data released
    initial begin
        scl_out     = 1'h1;
        sda_low_out = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // data falls while clock high opens a frame
    task automatic start();
        sda_low_out <= 1'h1;
        tick(4);
        scl_out <= 1'h0;
        tick(2);
    endtask
    // release data, raise clock, open again
    task automatic restart();
        sda_low_out <= 1'h0;
        tick(2);
        scl_out <= 1'h1;
        tick(4);
        start();
    endtask
    // data rises while clock high closes a frame
    task automatic stop();
        sda_low_out <= 1'h1;
        tick(2);
        scl_out <= 1'h1;
        tick(4);
        sda_low_out <= 1'h0;
        tick(8);
    endtask
    // data set in the low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        sda_low_out <= ~b;
        tick(2);
        scl_out <= 1'h1;
        tick(2);
        s = sda_in;
        tick(2);
        scl_out <= 1'h0;
        tick(2);
    endtask
    // byte out msb first, then sample the acknowledge
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'h1, s);
        ack = ~s;
    endtask
    // byte in msb first, then acknowledge or refuse
    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, s);
            d[i] = s;
        end
        bit_io(nack, s);
    endtask
endmodule // i2c_master_model

// file: test/i2c_nvsram_memory_slave_test.sv
module i2c_nvsram_memory_slave_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int         STORE_CYC = 4;     // short store for simulation
    localparam logic [7:0] SEL       = 8'ha8; // memory code, straps 10, write
    logic       ref_clk_in       = 1'h0;
    logic       sys_rst_in       = 1'h1;
    logic       write_protect_in = 1'h0;
    logic [1:0] straps           = 2'h2;
    logic       ext_store_low    = 1'h0;
    logic       ack;
    logic [7:0] d;
    logic [7:0] mem [0:131071];
    wire        scl, m_low, sda_out, sda_oe_n, busy_out, busy_oe_n, mem_wr;
    wire [16:0] mem_addr;
    wire [7:0]  mem_wdata;
    wire [7:0]  mem_rdata = mem[mem_addr];
    // wired lines with pull-ups
    wire        sda_line  = m_low ? 1'h0 : (sda_oe_n ? 1'h1 : sda_out);
    wire        busy_line = busy_oe_n ? ~ext_store_low : busy_out;
    int         fail_count = 0;
    int         n_tests = 0;
    typedef struct {logic [1:0] st; logic [7:0] sel; logic ok;} row_t;
    // straps, select byte, expected acknowledge
    row_t rows [7] = '{'{2'h2, 8'ha8, 1'h1}, '{2'h2, 8'ha9, 1'h1}, '{2'h2, 8'ha0, 1'h0},
        '{2'h0, 8'ha0, 1'h1}, '{2'h3, 8'hac, 1'h1}, '{2'h3, 8'hf0, 1'h0}, '{2'h3, 8'h3c, 1'h0}};

    always #50 ref_clk_in = ~ref_clk_in;
    // array model
    always @(posedge ref_clk_in) begin
        if (mem_wr === 1'h1) mem[mem_addr] <= mem_wdata;
    end
    i2c_nvsram_memory_slave #(.STORE_CYC(STORE_CYC)) u_dut (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .write_protect_in(write_protect_in),
        .address_select_pins_in(straps), .store_busy_pin_in(busy_line),
        .store_busy_pin_out(busy_out), .store_busy_pin_oe_n_out(busy_oe_n),
        .mem_wr_out(mem_wr), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
        .mem_rdata_in(mem_rdata));
    i2c_master_model u_master (.clk_in(ref_clk_in), .sda_in(sda_line), .scl_out(scl),
        .sda_low_out(m_low));

    function automatic logic [7:0] pat(input logic [16:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction
    task automatic check(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            fail_count++;
            $display("Error at %0t ns: %s", $time, msg);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // select for write, then the two low address bytes
    task automatic tx_addr(input logic [16:0] a);
        u_master.start();
        u_master.write_byte(SEL | {6'h0, a[16], 1'h0}, ack);
        check(ack === 1'h1, "select refused");
        u_master.write_byte(a[15:8], ack);
        check(ack === 1'h1, "address high refused");
        u_master.write_byte(a[7:0], ack);
        check(ack === 1'h1, "address low refused");
    endtask
    task automatic wait_busy(input logic oe, input logic v);
        int k;
        for (k = 0; k < 40 && !(busy_oe_n === oe && busy_out === v); k++) @(posedge ref_clk_in);
        if (k == 40) begin
            fail_count++;
            $display("Error at %0t ns: store pin wait ran out", $time);
            final_report();
        end
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk_in);
        fail_count++;
        $display("Error at %0t ns: run timed out", $time);
        final_report();
    end
    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = pat(17'(i));
        repeat (11) @(posedge ref_clk_in);
        check(sda_oe_n === 1'h1 && busy_oe_n === 1'h1 && mem_wr === 1'h0, "reset drive");
        check(mem_addr === 17'h0, "reset address");
        @(posedge ref_clk_in);
        sys_rst_in <= 1'h0;
        // select decoding: straps, codes and read
        foreach (rows[i]) begin
            straps <= rows[i].st;
            repeat (4) @(posedge ref_clk_in);
            u_master.start();
            u_master.write_byte(rows[i].sel, ack);
            check(ack === rows[i].ok, "select answer");
            if (rows[i].ok && rows[i].sel[0]) begin
                u_master.read_byte(1'h1, d);
                check(d === pat(17'h0), "first read address");
            end
            if (!rows[i].ok) begin
                u_master.write_byte({4'ha, rows[i].st, 2'h0}, ack);
                check(ack === 1'h0, "ignored frame answered");
            end
            u_master.stop();
        end
        straps <= 2'h2;
        // burst across the top of the array
        tx_addr(17'h1fffe);
        for (int i = 1; i <= 3; i++) begin
            u_master.write_byte(8'(i * 17), ack);
            check(ack === 1'h1, "burst byte refused");
        end
        u_master.stop();
        // random read back through a restart
        tx_addr(17'h1fffe);
        u_master.restart();
        u_master.write_byte(SEL | 8'h03, ack);
        check(ack === 1'h1, "read select refused");
        for (int i = 1; i <= 3; i++) begin
            u_master.read_byte(i == 3, d);
            check(d === 8'(i * 17), "burst read data");
        end
        u_master.stop();
        // current address read follows the wrapped burst
        u_master.start();
        u_master.write_byte(SEL | 8'h01, ack);
        u_master.read_byte(1'h1, d);
        check(d === pat(17'h1), "current address read");
        u_master.stop();
        check(mem[17'h1fffe] === 8'h11 && mem[17'h0] === 8'h33, "array contents");
        // protected write: data refused, rest ignored
        write_protect_in <= 1'h1;
        tx_addr(17'h00010);
        u_master.write_byte(8'hee, ack);
        check(ack === 1'h0, "protected data acknowledged");
        u_master.write_byte(8'h77, ack);
        check(ack === 1'h0, "byte after refusal acknowledged");
        u_master.stop();
        write_protect_in <= 1'h0;
        check(mem[17'h10] === pat(17'h10), "protected location written");
        // hardware store request through the pin
        ext_store_low <= 1'h1;
        repeat (2) @(posedge ref_clk_in);
        ext_store_low <= 1'h0;
        wait_busy(1'h0, 1'h0);
        check(busy_line === 1'h0, "store pin not low");
        wait_busy(1'h0, 1'h1);
        @(posedge ref_clk_in);
        check(busy_oe_n === 1'h1, "store pin not released");
        final_report();
    end
endmodule // i2c_nvsram_memory_slave_test

// file: test/i2c_nvsram_slave_asserts.sv
module i2c_nvsram_slave_asserts #(
    parameter STORE_CYC = 4
) (
    input wire ref_clk_in,              // system clock
    input wire sys_rst_in,              // async reset
    input wire scl_in,                  // serial clock
    input wire sda_out,                 // data drive value
    input wire sda_oe_n_out,            // low while pulling data
    input wire write_protect_in,        // write block
    input wire store_busy_pin_in,       // store pin level
    input wire store_busy_pin_out,      // store pin drive value
    input wire store_busy_pin_oe_n_out, // low while driving pin
    input wire mem_wr_out               // array write strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [15:0] low_cnt;
    logic [4:0]  wp_cnt;
    logic [3:0]  hi_cnt;
    // run lengths of store drive low, protect high and clock high
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            low_cnt <= 16'h0;
            wp_cnt  <= 5'h0;
            hi_cnt  <= 4'h0;
        end else begin
            low_cnt <= (!store_busy_pin_oe_n_out && !store_busy_pin_out) ? low_cnt + 16'h1 : 16'h0;
            wp_cnt  <= !write_protect_in ? 5'h0 : (wp_cnt == 5'h1f) ? wp_cnt : wp_cnt + 5'h1;
            hi_cnt  <= !scl_in ? 4'h0 : (hi_cnt == 4'hf) ? hi_cnt : hi_cnt + 4'h1;
        end
    end
    a_sda_never_high: assert property (
        sda_out == 1'h0) else $error("data pin driven high");
    a_sda_stable_high: assert property (
        scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe_n_out))
        else $error("data drive changed while clock high");
    a_idle_released: assert property (
        hi_cnt == 4'hf |-> sda_oe_n_out) else $error("data held low on idle bus");
    a_protect_blocks: assert property (
        wp_cnt == 5'h1f |-> !mem_wr_out) else $error("array written while protected");
    a_write_strobe_single: assert property (
        mem_wr_out |=> !mem_wr_out) else $error("write strobe longer than a cycle");
    a_store_request: assert property (
        $fell(store_busy_pin_in) && store_busy_pin_oe_n_out |-> ##[1:8] !store_busy_pin_oe_n_out)
        else $error("store request not answered");
    a_store_length: assert property (
        !store_busy_pin_oe_n_out && store_busy_pin_out |->
        low_cnt >= STORE_CYC - 1 && low_cnt <= STORE_CYC + 1) else $error("store length wrong");
    a_store_high_brief: assert property (
        !store_busy_pin_oe_n_out && store_busy_pin_out |=> store_busy_pin_oe_n_out)
        else $error("store pin driven high too long");
    c_write: cover property (mem_wr_out);
    c_ack: cover property (!sda_oe_n_out && scl_in);
    c_store: cover property ($fell(store_busy_pin_oe_n_out));
endmodule // i2c_nvsram_slave_asserts

bind i2c_nvsram_memory_slave i2c_nvsram_slave_asserts #(.STORE_CYC(STORE_CYC)) u_asserts (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out), .write_protect_in(write_protect_in),
    .store_busy_pin_in(store_busy_pin_in), .store_busy_pin_out(store_busy_pin_out),
    .store_busy_pin_oe_n_out(store_busy_pin_oe_n_out), .mem_wr_out(mem_wr_out));
